// >>> design/sdr_pkg.sv
package sdr_pkg;
    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    localparam int ADDR_W = 11;
    localparam int AP_BIT = 10;
    localparam int MR_CL_LSB = 4;
    localparam int MR_BL_LSB = 0;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [1:0] RST_CL = 2'h3;
    localparam logic [2:0] RST_BL = 3'h0;
    localparam int TCK_PS = 40000;
    localparam int GRADES = 4;
    // interval figures in ps, one entry per speed grade except T_WR2_PS, fastest grade first; the last two are in clocks
    localparam int T_RC_PS [GRADES] = '{60000, 63000, 66000, 70000};
    localparam int T_RP_PS [GRADES] = '{15000, 17000, 18000, 21000};
    localparam int T_RCD_PS [GRADES] = '{15000, 16500, 18000, 18000};
    localparam int T_WR3_PS [GRADES] = '{5000, 5500, 6000, 7000};
    localparam int T_WR2_PS = 10000;
    localparam int SREX_CLK = 2;
    localparam int MRS_GAP_CYC = 2;

    function automatic int sdr_cyc(input int ps);
        int c;
        c = (ps + TCK_PS - 1) / TCK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        SDR_MRS = 4'h0,
        SDR_REF = 4'h1,
        SDR_PRE = 4'h2,
        SDR_ACT = 4'h3,
        SDR_WR = 4'h4,
        SDR_RD = 4'h5,
        SDR_BST = 4'h6,
        SDR_NOP = 4'h7,
        SDR_DESEL = 4'hf
    } sdr_cmd_e;

    typedef enum logic [2:0] {
        C_INIT = 3'h0,
        C_PALL = 3'h1,
        C_MRS = 3'h2,
        C_IDLE = 3'h3,
        C_RCD = 3'h4,
        C_WAIT = 3'h5,
        C_SREF = 3'h6,
        C_SREX = 3'h7
    } sdr_cst_e;
endpackage

// >>> design/sdr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdr_link_if;
    import sdr_pkg::*;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic ba;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] dqm;
    logic [DQ_W-1:0] dq_ctl;
    logic dq_ctl_oe;
    logic [DQ_W-1:0] dq_mem;
    logic [LANES-1:0] dq_mem_oe;
    logic [DQ_W-1:0] dq;

    // memory wins a clash, so contention shows up as wrong write data
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        assign dq[l*LANE_W +: LANE_W] = dq_mem_oe[l] ? dq_mem[l*LANE_W +: LANE_W] :
                                        (dq_ctl_oe ? dq_ctl[l*LANE_W +: LANE_W] : '0);
    end

    modport ctrl (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl, dq_ctl_oe,
        input dq
    );
    modport mem (
        input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
        output dq_mem, dq_mem_oe
    );
endinterface
`default_nettype wire

// >>> design/sdr_mem_end.sv
`timescale 1ns/1ps
`default_nettype none
module sdr_mem_end
    import sdr_pkg::*;
#(
    parameter int ROW_W = 2,
    parameter int COL_W = 4
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // link to controller
    sdr_link_if.mem link,
    // status
    output logic in_self_refresh_o,
    output logic burst_active_o,
    output logic [1:0] cas_latency_o,
    output logic [1:0] row_open_o
);
    localparam int IDX_W = 1 + ROW_W + COL_W;
    localparam int WORDS = 1 << IDX_W;
    localparam int LEFT_W = COL_W + 1;

    typedef struct packed {
        logic [WORDS-1:0][DQ_W-1:0] mem;
        logic [1:0] cl;
        logic [2:0] bl;
        logic sref;
        logic exit_arm;
        logic [1:0] row_open;
        logic [1:0][ROW_W-1:0] row;
        logic rd_act;
        logic wr_act;
        logic busy;
        logic bank;
        logic ap;
        logic [COL_W-1:0] col;
        logic [LEFT_W-1:0] left;
        logic [1:0] pv;
        logic [1:0][DQ_W-1:0] pd;
        logic [LANES-1:0] dqm_d;
        logic [DQ_W-1:0] dq_o;
        logic [LANES-1:0] dq_oe;
    } sdr_mem_s;

    sdr_mem_s st;
    sdr_mem_s next_st;

    sdr_cmd_e cmd;
    logic take;
    logic term;
    logic start;
    logic b_rd;
    logic b_wr;
    logic b_bank;
    logic b_ap;
    logic [COL_W-1:0] b_col;
    logic [LEFT_W-1:0] b_left;
    logic [IDX_W-1:0] idx;
    logic last;
    logic tap;
    logic [DQ_W-1:0] wr_word;
    logic [LANES-1:0] next_oe;

    function automatic logic [LEFT_W-1:0] burst_len(input logic [2:0] bl);
        logic [LEFT_W-1:0] n;
        case (bl)
            3'h0: n = LEFT_W'(1);
            3'h1: n = LEFT_W'(2);
            3'h2: n = LEFT_W'(4);
            3'h3: n = LEFT_W'(8);
            default: n = LEFT_W'(1);
        endcase
        return n;
    endfunction

    assign cmd = link.cs_n ? SDR_DESEL : sdr_cmd_e'({1'b0, link.ras_n, link.cas_n, link.we_n});

    // all commands but self refresh entry count only with clock enable high and outside self refresh
    assign take = link.cke && !st.sref;

    // any column or stop command ends the running burst at this edge
    assign term = take && (cmd inside {SDR_RD, SDR_WR, SDR_BST, SDR_PRE});

    // a column command to a closed bank is dropped
    assign start = take && (cmd inside {SDR_RD, SDR_WR}) && st.row_open[link.ba];

    // clock enable low ends the running burst at this edge, with no beat (no clock suspend)
    assign b_rd = start ? (cmd == SDR_RD) : (st.rd_act && !term && link.cke);
    assign b_wr = start ? (cmd == SDR_WR) : (st.wr_act && !term && link.cke);
    assign b_bank = start ? link.ba : st.bank;
    assign b_ap = start ? link.addr[AP_BIT] : st.ap;
    assign b_col = start ? link.addr[COL_W-1:0] : st.col;
    assign b_left = start ? burst_len(st.bl) : st.left;
    assign idx = {b_bank, st.row[b_bank], b_col};
    assign last = (st.bl != BL_FULL) && (b_left == LEFT_W'(1));

    // pipe stage 0 feeds a latency of 2, stage 1 a latency of 3
    assign tap = (st.cl == 2'h2) ? 1'b0 : 1'b1;

    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        // mask sampled last edge blanks the word seen at the edge after next
        assign next_oe[l] = st.pv[tap] && !st.dqm_d[l];
        // masked lane keeps the stored byte, no latency
        assign wr_word[l*LANE_W +: LANE_W] = link.dqm[l] ?
            st.mem[idx][l*LANE_W +: LANE_W] : link.dq[l*LANE_W +: LANE_W];
    end

    always_comb
    begin
        next_st = st;
        next_st.dqm_d = link.dqm;
        next_st.dq_oe = next_oe;
        next_st.dq_o = st.pd[tap];
        // words already fetched keep draining after a stop
        next_st.pv = {st.pv[0], 1'b0};
        next_st.pd[1] = st.pd[0];

        if (st.sref)
        begin
            if (st.exit_arm)
            begin
                next_st.sref = 1'b0;
                next_st.exit_arm = 1'b0;
            end
            else if (link.cke)
            begin
                next_st.exit_arm = 1'b1;
            end
        end
        else if (!link.cke && cmd == SDR_REF)
        begin
            next_st.sref = 1'b1;
        end

        next_st.rd_act = b_rd && !last;
        next_st.wr_act = b_wr && !last;
        if (b_rd || b_wr)
        begin
            next_st.bank = b_bank;
            next_st.ap = b_ap;
            next_st.col = COL_W'(b_col + 1'b1);
            next_st.left = LEFT_W'(b_left - 1'b1);
            if (last && b_ap)
            begin
                next_st.row_open[b_bank] = 1'b0;
            end
        end
        if (b_rd)
        begin
            next_st.pv[0] = 1'b1;
            next_st.pd[0] = st.mem[idx];
        end
        if (b_wr)
        begin
            next_st.mem[idx] = wr_word;
        end

        if (take)
        begin
            case (cmd)
                SDR_ACT:
                begin
                    next_st.row_open[link.ba] = 1'b1;
                    next_st.row[link.ba] = link.addr[ROW_W-1:0];
                end
                SDR_PRE:
                begin
                    if (link.addr[AP_BIT])
                    begin
                        next_st.row_open = 2'h0;
                    end
                    else
                    begin
                        next_st.row_open[link.ba] = 1'b0;
                    end
                end
                SDR_MRS:
                begin
                    next_st.cl = link.addr[MR_CL_LSB +: 2];
                    next_st.bl = link.addr[MR_BL_LSB +: 3];
                end
                default:
                begin
                end
            endcase
        end

        next_st.busy = next_st.rd_act || next_st.wr_act;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st <= '0;
            st.cl <= RST_CL;
            st.bl <= RST_BL;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign link.dq_mem = st.dq_o;
    assign link.dq_mem_oe = st.dq_oe;
    assign in_self_refresh_o = st.sref;
    assign burst_active_o = st.busy;
    assign cas_latency_o = st.cl;
    assign row_open_o = st.row_open;
endmodule
`default_nettype wire

// >>> design/sdr_ctrl_end.sv
`timescale 1ns/1ps
`default_nettype none
module sdr_ctrl_end
    import sdr_pkg::*;
#(
    parameter int GRADE = 0,
    parameter int CAS_LAT = 3,
    parameter int INIT_CYC = 16
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // link to memory
    sdr_link_if.ctrl link,
    // request from user
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_bank_i,
    input wire logic [ADDR_W-1:0] req_row_i,
    input wire logic [AP_BIT-1:0] req_col_i,
    input wire logic [DQ_W-1:0] req_wdata_i,
    input wire logic [LANES-1:0] req_mask_i,
    input wire logic sref_req_i,
    // answer to user
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic [DQ_W-1:0] rd_data_o,
    output logic sref_active_o,
    output logic init_done_o
);
    localparam int CNT_W = 16;
    // counts per speed grade; write recovery also follows the CAS latency
    localparam int RC = sdr_cyc(T_RC_PS[GRADE]);
    localparam int RP = sdr_cyc(T_RP_PS[GRADE]);
    localparam int RCD = sdr_cyc(T_RCD_PS[GRADE]);
    localparam int WR = (CAS_LAT == 2) ? sdr_cyc(T_WR2_PS) : sdr_cyc(T_WR3_PS[GRADE]);
    localparam int WAIT_WR = (WR + RP > RC - RCD) ? WR + RP : RC - RCD;
    localparam int RD_PRE = (RP + 1 > RC - RCD) ? RP + 1 : RC - RCD;
    localparam int WAIT_RD = (RD_PRE > CAS_LAT + 1) ? RD_PRE : CAS_LAT + 1;
    localparam int SREX_WAIT = SREX_CLK + RC;

    typedef struct packed {
        sdr_cst_e state;
        logic [CNT_W-1:0] cnt;
        logic [2:0] rd_cnt;
        logic cke;
        sdr_cmd_e cmd;
        logic ba;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] dqm;
        logic [DQ_W-1:0] dq;
        logic dq_oe;
        logic wr;
        logic [AP_BIT-1:0] col;
        logic [LANES-1:0] mask;
        logic [DQ_W-1:0] wdata;
        logic ready;
        logic rd_valid;
        logic [DQ_W-1:0] rd_data;
        logic sref;
        logic done;
    } sdr_ctrl_s;

    sdr_ctrl_s st;
    sdr_ctrl_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.cmd = SDR_NOP;
        // write data stands only in its command cycle, long before any read data
        next_st.dq_oe = 1'b0;
        next_st.dqm = '0;
        next_st.rd_valid = 1'b0;
        if (st.rd_cnt != 3'h0)
        begin
            next_st.rd_cnt = st.rd_cnt - 3'h1;
        end
        if (st.rd_cnt == 3'h1)
        begin
            next_st.rd_valid = 1'b1;
            next_st.rd_data = link.dq;
        end
        if (st.cnt != '0)
        begin
            next_st.cnt = st.cnt - CNT_W'(1);
        end
        case (st.state)
            C_INIT:
            begin
                if (st.cnt == '0)
                begin
                    next_st.cmd = SDR_PRE;
                    next_st.addr = '0;
                    next_st.addr[AP_BIT] = 1'b1;
                    next_st.state = C_PALL;
                    next_st.cnt = CNT_W'(RP - 1);
                end
            end
            C_PALL:
            begin
                if (st.cnt == '0)
                begin
                    next_st.cmd = SDR_MRS;
                    next_st.addr = ADDR_W'(CAS_LAT) << MR_CL_LSB;
                    next_st.state = C_MRS;
                    next_st.cnt = CNT_W'(MRS_GAP_CYC - 1);
                end
            end
            C_MRS:
            begin
                if (st.cnt == '0)
                begin
                    next_st.state = C_IDLE;
                    next_st.done = 1'b1;
                    next_st.ready = 1'b1;
                end
            end
            C_IDLE:
            begin
                if (sref_req_i)
                begin
                    next_st.cmd = SDR_REF;
                    next_st.cke = 1'b0;
                    next_st.ready = 1'b0;
                    next_st.sref = 1'b1;
                    next_st.state = C_SREF;
                end
                else if (req_valid_i && st.ready)
                begin
                    next_st.cmd = SDR_ACT;
                    next_st.ba = req_bank_i;
                    next_st.addr = req_row_i;
                    next_st.wr = req_write_i;
                    next_st.col = req_col_i;
                    next_st.wdata = req_wdata_i;
                    next_st.mask = req_mask_i;
                    next_st.ready = 1'b0;
                    next_st.state = C_RCD;
                    next_st.cnt = CNT_W'(RCD - 1);
                end
            end
            C_RCD:
            begin
                if (st.cnt == '0)
                begin
                    next_st.cmd = st.wr ? SDR_WR : SDR_RD;
                    next_st.addr = {1'b1, st.col};
                    next_st.state = C_WAIT;
                    if (st.wr)
                    begin
                        next_st.dq_oe = 1'b1;
                        next_st.dq = st.wdata;
                        next_st.dqm = st.mask;
                        next_st.cnt = CNT_W'(WAIT_WR - 1);
                    end
                    else
                    begin
                        next_st.rd_cnt = 3'(CAS_LAT + 1);
                        next_st.cnt = CNT_W'(WAIT_RD - 1);
                    end
                end
            end
            C_WAIT:
            begin
                if (st.cnt == '0)
                begin
                    next_st.state = C_IDLE;
                    next_st.ready = 1'b1;
                end
            end
            C_SREF:
            begin
                next_st.cke = 1'b0;
                if (!sref_req_i)
                begin
                    next_st.cke = 1'b1;
                    next_st.state = C_SREX;
                    next_st.cnt = CNT_W'(SREX_WAIT - 1);
                end
            end
            C_SREX:
            begin
                if (st.cnt == '0)
                begin
                    next_st.state = C_IDLE;
                    next_st.sref = 1'b0;
                    next_st.ready = 1'b1;
                end
            end
            default:
            begin
                next_st.state = C_INIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st <= '0;
            st.cnt <= CNT_W'(INIT_CYC - 1);
            st.cke <= 1'b1;
            st.cmd <= SDR_NOP;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign link.cke = st.cke;
    assign link.cs_n = st.cmd[3];
    assign link.ras_n = st.cmd[2];
    assign link.cas_n = st.cmd[1];
    assign link.we_n = st.cmd[0];
    assign link.ba = st.ba;
    assign link.addr = st.addr;
    assign link.dqm = st.dqm;
    assign link.dq_ctl = st.dq;
    assign link.dq_ctl_oe = st.dq_oe;
    assign req_ready_o = st.ready;
    assign rd_valid_o = st.rd_valid;
    assign rd_data_o = st.rd_data;
    assign sref_active_o = st.sref;
    assign init_done_o = st.done;
endmodule
`default_nettype wire

// >>> bench/sdr_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sdr_link_checker
    import sdr_pkg::*;
#(
    parameter int CAS_LAT = 3
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // command side
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES-1:0] dqm,
    // data side
    input wire logic dq_ctl_oe,
    input wire logic [LANES-1:0] dq_mem_oe
);
    logic [3:0] cmd;
    logic [3:0] rd_hist;

    assign cmd = {cs_n, ras_n, cas_n, we_n};

    // one bit per edge since a read was taken
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rd_hist <= '0;
        else
            rd_hist <= {rd_hist[2:0], cke && cmd == SDR_RD};
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_read_data_lat: assert property (rd_hist[CAS_LAT-1] == (dq_mem_oe == 2'h3))
        else $error("read data off its latency cycle");
    a_mask_read_off: assert property ((dq_mem_oe & $past(dqm, 2)) == 2'h0)
        else $error("masked lane still driven");
    a_bus_turn_free: assert property (|dq_mem_oe |-> !dq_ctl_oe && !$past(dq_ctl_oe))
        else $error("write data not released before read data");
    a_write_data_same: assert property ((cmd == SDR_WR) == dq_ctl_oe)
        else $error("write data not with its command");
    a_col_after_act: assert property ((cmd == SDR_RD || cmd == SDR_WR) |-> $past(cmd) == SDR_ACT && addr[AP_BIT])
        else $error("column command without activate or auto precharge");
    a_act_spacing: assert property (cmd == SDR_ACT |=> (cmd != SDR_ACT) [*3])
        else $error("bank activated again too soon");
    a_write_recover: assert property (cmd == SDR_WR |=> (cmd == SDR_NOP) [*2])
        else $error("command inside write recovery");
    a_sref_entry: assert property ($fell(cke) |-> cmd == SDR_REF && dq_mem_oe == 2'h0)
        else $error("clock enable dropped without self refresh");
    a_sref_exit_wait: assert property ($rose(cke) |-> (cmd == SDR_NOP) [*4])
        else $error("command before self refresh exit completed");
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
    begin \
        n_tests++; \
        if ((act) !== (exp)) \
        begin \
            n_errors++; \
            $display("Error at %0t: got %0h expected %0h", $time, (act), (exp)); \
        end \
    end
module tb_top
    import sdr_pkg::*;
;
    localparam int CL = 3;
    logic sys_clk_i;
    logic rst_b_i;
    logic req_valid_i;
    logic req_write_i;
    logic req_bank_i;
    logic [ADDR_W-1:0] req_row_i;
    logic [AP_BIT-1:0] req_col_i;
    logic [DQ_W-1:0] req_wdata_i;
    logic [LANES-1:0] req_mask_i;
    logic sref_req_i;
    logic req_ready_o;
    logic rd_valid_o;
    logic [DQ_W-1:0] rd_data_o;
    logic sref_active_o;
    logic in_sref_a;
    logic in_sref_b;
    logic [1:0] cl_b;
    logic busy_b;
    logic [1:0] rows_b;
    logic init_done_o;
    logic [DQ_W-1:0] mdl [2][4][16] = '{default: '0};
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    sdr_link_if link_a ();
    sdr_link_if link_b ();
    sdr_ctrl_end #(.GRADE(0), .CAS_LAT(CL), .INIT_CYC(4)) sdr_ctrl_end_inst (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(link_a.ctrl), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_bank_i(req_bank_i), .req_row_i(req_row_i), .req_col_i(req_col_i),
        .req_wdata_i(req_wdata_i), .req_mask_i(req_mask_i), .sref_req_i(sref_req_i), .req_ready_o(req_ready_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .sref_active_o(sref_active_o),
        .init_done_o(init_done_o));
    sdr_mem_end sdr_mem_end_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .link(link_a.mem), .in_self_refresh_o(in_sref_a), .burst_active_o(), .cas_latency_o(), .row_open_o());
    // second memory faces the bench, which makes the bursts the controller never issues
    sdr_mem_end sdr_mem_end_b_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .link(link_b.mem), .in_self_refresh_o(in_sref_b), .burst_active_o(busy_b), .cas_latency_o(cl_b),
        .row_open_o(rows_b));
    sdr_link_checker #(.CAS_LAT(CL)) sdr_link_checker_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .cke(link_a.cke), .cs_n(link_a.cs_n), .ras_n(link_a.ras_n), .cas_n(link_a.cas_n), .we_n(link_a.we_n),
        .addr(link_a.addr), .dqm(link_a.dqm), .dq_ctl_oe(link_a.dq_ctl_oe), .dq_mem_oe(link_a.dq_mem_oe));

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] mk);
        return {mk[1] ? old[15:8] : nw[15:8], mk[0] ? old[7:0] : nw[7:0]};
    endfunction

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready_o !== 1'h1 && n < 300)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic req(input logic wr, input logic bk, input logic [1:0] row, input logic [3:0] col,
                       input logic [15:0] wd, input logic [1:0] mk);
        int n;
        n = 0;
        wait_ready();
        req_valid_i = 1'h1;
        req_write_i = wr;
        req_bank_i = bk;
        req_row_i = 11'(row);
        req_col_i = 10'(col);
        req_wdata_i = wd;
        req_mask_i = mk;
        tick(1);
        req_valid_i = 1'h0;
        if (wr)
            mdl[bk][row][col] = merge(mdl[bk][row][col], wd, mk);
        else
        begin
            while (rd_valid_o !== 1'h1 && n < 20)
            begin
                tick(1);
                n++;
            end
            `CHK(rd_valid_o, 1'h1)
            `CHK(rd_data_o, mdl[bk][row][col])
        end
    endtask

    task automatic issue(input logic [3:0] c, input logic [10:0] ad, input logic [1:0] mk,
                         input logic oe, input logic [15:0] wd);
        {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = c;
        link_b.addr = ad;
        link_b.dqm = mk;
        link_b.dq_ctl_oe = oe;
        link_b.dq_ctl = wd;
        tick(1);
    endtask

    task automatic nop(input int n);
        repeat (n) issue(SDR_NOP, 11'h0, 2'h0, 1'h0, 16'h0);
    endtask

    // full-page read ended at once: only the word fetched with the command arrives
    task automatic rd_one(input logic [10:0] col, input logic [15:0] exp);
        issue(SDR_RD, col, 2'h0, 1'h0, 16'h0);
        issue(SDR_BST, 11'h0, 2'h0, 1'h0, 16'h0);
        `CHK(link_b.dq, exp)
        nop(1);
    endtask

    initial
    begin
        sys_clk_i = 1'h0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        int n;
        rst_b_i = 1'h0;
        {req_valid_i, req_write_i, req_bank_i, sref_req_i} = 4'h0;
        {req_row_i, req_col_i, req_wdata_i, req_mask_i} = '0;
        {link_b.cke, link_b.ba, link_b.addr, link_b.dqm, link_b.dq_ctl, link_b.dq_ctl_oe} = {1'h1, 31'h0};
        {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = SDR_NOP;
        void'($urandom(30));
        tick(16);
        rst_b_i = 1'h1;
        `CHK(init_done_o, 1'h0)
        req(1'h1, 1'h0, 2'h2, 4'h5, 16'ha5c3, 2'h0);
        req(1'h1, 1'h0, 2'h2, 4'h5, 16'h1234, 2'h1);
        req(1'h0, 1'h0, 2'h2, 4'h5, 16'h0, 2'h0);
        req(1'h1, 1'h0, 2'h2, 4'h5, 16'hffff, 2'h3);
        req(1'h0, 1'h0, 2'h2, 4'h5, 16'h0, 2'h0);
        req(1'h1, 1'h1, 2'h3, 4'hf, 16'hbeef, 2'h2);
        req(1'h0, 1'h1, 2'h3, 4'hf, 16'h0, 2'h0);
        wait_ready();
        sref_req_i = 1'h1;
        tick(8);
        `CHK({link_a.cke, sref_active_o, in_sref_a}, 3'h3)
        sref_req_i = 1'h0;
        n = 0;
        while (link_a.cke !== 1'h1 && n < 10)
        begin
            tick(1);
            n++;
        end
        n = 0;
        while (req_ready_o !== 1'h1 && n < 20)
        begin
            tick(1);
            n++;
        end
        // n misses the edge that raised clock enable, so that edge is added back
        `CHK(n + 1 >= 2 + (T_RC_PS[0] + TCK_PS - 1) / TCK_PS, 1'h1)
        `CHK(req_ready_o, 1'h1)
        `CHK(in_sref_a, 1'h0)
        `CHK(init_done_o, 1'h1)
        req(1'h0, 1'h0, 2'h2, 4'h5, 16'h0, 2'h0);
        repeat (60) req(1'($urandom), 1'($urandom), 2'($urandom), 4'($urandom), 16'($urandom), 2'($urandom));
        issue(SDR_MRS, 11'h027, 2'h0, 1'h0, 16'h0);
        nop(2);
        `CHK(cl_b, 2'h2)
        link_b.cke = 1'h0;
        issue(SDR_REF, 11'h0, 2'h0, 1'h0, 16'h0);
        nop(3);
        `CHK(in_sref_b, 1'h1)
        link_b.cke = 1'h1;
        nop(1);
        `CHK(in_sref_b, 1'h1)
        nop(1);
        `CHK(in_sref_b, 1'h0)
        nop(3);
        issue(SDR_ACT, 11'h1, 2'h0, 1'h0, 16'h0);
        nop(1);
        issue(SDR_WR, 11'h0, 2'h0, 1'h1, 16'h1111);
        `CHK({busy_b, rows_b}, 3'h5)
        issue(SDR_NOP, 11'h0, 2'h2, 1'h1, 16'h2222);
        issue(SDR_NOP, 11'h0, 2'h0, 1'h1, 16'h3333);
        issue(SDR_BST, 11'h0, 2'h0, 1'h1, 16'h4444);
        nop(1);
        `CHK(busy_b, 1'h0)
        issue(SDR_RD, 11'h0, 2'h0, 1'h0, 16'h0);
        issue(SDR_NOP, 11'h0, 2'h2, 1'h0, 16'h0);
        `CHK(link_b.dq, 16'h1111)
        issue(SDR_BST, 11'h0, 2'h0, 1'h0, 16'h0);
        `CHK({link_b.dq_mem_oe, link_b.dq}, {2'h1, 16'h0022})
        nop(1);
        `CHK(link_b.dq_mem_oe, 2'h0)
        rd_one(11'h1, 16'h0022);
        rd_one(11'h2, 16'h3333);
        rd_one(11'h3, 16'h0000);
        // a read to a closed bank must be dropped, so no data may follow it
        issue(SDR_PRE, 11'h0, 2'h0, 1'h0, 16'h0);
        `CHK(rows_b, 2'h0)
        issue(SDR_RD, 11'h0, 2'h0, 1'h0, 16'h0);
        nop(1);
        `CHK(link_b.dq_mem_oe, 2'h0)
        tally_and_finish();
    end
endmodule
`undef CHK
`default_nettype wire
